// ---- verilog/eeprom_spi_front_end.sv ----
// serial eeprom front end: link shifter, array, status and write timer
`default_nettype none
`include "eeprom_spi_params.svh"
module eeprom_spi_front_end #(
  parameter int DEPTH        = `EE_ARRAY_DEPTH,
  parameter int WRITE_CYCLES = `EE_T_WRITE_US * `EE_CORE_MHZ
) (
  // core clock and reset
  input  wire logic I_CORE_CLK,
  input  wire logic I_RESETN,
  // serial link
  input  wire logic I_SER_CLK,
  input  wire logic I_SEL_N,
  input  wire logic I_SI,
  input  wire logic I_HOLD_N,
  input  wire logic I_WP_N,
  output logic      O_SO,
  output logic      O_SO_OE,
  // status
  output logic      O_STANDBY,
  output logic      O_WRITE_BUSY,
  output logic      O_PAUSED
);
  import eeprom_spi_pkg::*;

  localparam int ADDR_W = $clog2(DEPTH);
  localparam int CNT_W  = $clog2(WRITE_CYCLES + 1);

  // core domain
  logic              sel_n_core;
  logic              hold_n_core;
  logic              tgl_core;
  logic              tgl_seen;
  logic              next_tgl_seen;
  logic              armed;
  logic              next_armed;
  logic [CNT_W-1:0]  busy_cnt;
  logic [CNT_W-1:0]  next_busy_cnt;
  logic              next_busy;
  logic              next_standby;
  logic              next_paused;

  // link domain
  link_state_e       state;
  link_state_e       next_state;
  logic [2:0]        bit_cnt;
  logic [2:0]        next_bit_cnt;
  byte_t             shreg;
  byte_t             next_shreg;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] next_addr;
  byte_t             out_byte;
  byte_t             next_out_byte;
  logic              is_write;
  logic              next_is_write;
  logic              wr_ok;
  logic              next_wr_ok;
  logic              armed_lnk;
  logic              busy_lnk;
  logic              wp_n_lnk;
  logic              wen;
  logic              next_wen;
  logic [1:0]        bp;
  logic [1:0]        next_bp;
  logic              commit_tgl;
  logic              next_commit_tgl;
  logic              mem_we;
  byte_t             in_byte;
  byte_t             status;
  logic              active;
  logic              byte_done;
  logic              float_req;
  logic              next_so;
  logic              next_oe;

  // the whole array lives in the link domain, see RULE1
  byte_t             mem [0:DEPTH-1];

  function automatic logic protected_addr(input logic [ADDR_W-1:0] a,
                                          input logic [1:0]        b);
    logic hit;
    hit = 1'b0;
    unique case (b)
      2'h0: hit = 1'b0;
      2'h1: hit = (a[ADDR_W-1 -: 2] == 2'h3);
      2'h2: hit = a[ADDR_W-1];
      2'h3: hit = 1'b1;
    endcase
    return hit;
  endfunction

  // ---------------- core domain ----------------

  eeprom_sync2 #(
    .WIDTH (3)
  ) u_core_sync (
    .i_clk   (I_CORE_CLK),
    .i_async ({I_SEL_N, I_HOLD_N, commit_tgl}),
    .o_sync  ({sel_n_core, hold_n_core, tgl_core})
  );

  always_comb begin
    // power-up arming waits for select seen high, see RULE6
    next_armed    = armed | sel_n_core;
    next_tgl_seen = tgl_core;
    if (tgl_core != tgl_seen) begin
      next_busy_cnt = CNT_W'(WRITE_CYCLES);
    end else if (busy_cnt != '0) begin
      next_busy_cnt = busy_cnt - CNT_W'(1);
    end else begin
      next_busy_cnt = '0;
    end
    next_busy    = (next_busy_cnt != '0);
    // standby only when deselected and no write is timing, see RULE5
    next_standby = sel_n_core & ~next_busy;
    next_paused  = ~sel_n_core & ~hold_n_core;
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESETN) begin
      armed        <= 1'b0;
      tgl_seen     <= 1'b0;
      busy_cnt     <= '0;
      O_WRITE_BUSY <= 1'b0;
      O_STANDBY    <= 1'b1;
      O_PAUSED     <= 1'b0;
    end else begin
      armed        <= next_armed;
      tgl_seen     <= next_tgl_seen;
      busy_cnt     <= next_busy_cnt;
      O_WRITE_BUSY <= next_busy;
      O_STANDBY    <= next_standby;
      O_PAUSED     <= next_paused;
    end
  end

  // ---------------- link domain ----------------

  // armed and busy are slow levels; a stale busy only delays a write
  eeprom_sync2 #(
    .WIDTH (3)
  ) u_link_sync (
    .i_clk   (I_SER_CLK),
    .i_async ({armed, O_WRITE_BUSY, I_WP_N}),
    .o_sync  ({armed_lnk, busy_lnk, wp_n_lnk})
  );

  // pause only moves while the clock is low, so it is steady at a rise
  assign float_req = I_SEL_N | ~I_HOLD_N;

  always_comb begin
    // a paused rising edge is simply skipped, see RULE7 and RULE8
    active    = armed_lnk & I_HOLD_N;
    // msb first: new bit enters at the bottom, see RULE12
    in_byte   = {shreg[6:0], I_SI};
    byte_done = active && (bit_cnt == 3'h7);

    status                = 8'h00;
    status[`EE_SR_BUSY]   = busy_lnk;
    status[`EE_SR_WEN]    = wen;
    status[`EE_SR_BP_LO]  = bp[0];
    status[`EE_SR_BP_HI]  = bp[1];

    next_state      = state;
    next_bit_cnt    = bit_cnt;
    next_shreg      = shreg;
    next_addr       = addr;
    next_out_byte   = out_byte;
    next_is_write   = is_write;
    next_wr_ok      = wr_ok;
    next_wen        = wen;
    next_bp         = bp;
    next_commit_tgl = commit_tgl;
    mem_we          = 1'b0;

    if (active) begin
      // first rise after select falls is bit 0, see RULE3 and RULE13
      next_shreg   = in_byte;
      next_bit_cnt = bit_cnt + 3'h1;
    end

    if (byte_done) begin
      unique case (state)
        ST_CMD: begin
          next_state = ST_IGNORE;
          case (in_byte)
            `EE_OP_READ: begin
              next_state    = ST_ADDR_HI;
              next_is_write = 1'b0;
            end
            `EE_OP_WRITE: begin
              next_state    = ST_ADDR_HI;
              next_is_write = 1'b1;
              next_wr_ok    = wen & ~busy_lnk;
            end
            `EE_OP_RDSR: begin
              next_state    = ST_RSTAT;
              next_out_byte = status;
            end
            `EE_OP_WRSR: begin
              next_state = ST_WSTAT;
            end
            `EE_OP_WREN: begin
              next_wen = ~busy_lnk;
            end
            `EE_OP_WRDI: begin
              next_wen = busy_lnk & wen;
            end
            default: begin
              next_state = ST_IGNORE;
            end
          endcase
        end
        ST_ADDR_HI: begin
          next_addr[ADDR_W-1:8] = in_byte[ADDR_W-9:0];
          next_state            = ST_ADDR_LO;
        end
        ST_ADDR_LO: begin
          next_addr[7:0] = in_byte;
          if (is_write) begin
            next_state = ST_WDATA;
          end else begin
            // first data byte is ready before the next fall, see RULE14
            next_state    = ST_RDATA;
            next_out_byte = mem[{addr[ADDR_W-1:8], in_byte}];
            next_addr     = {addr[ADDR_W-1:8], in_byte} + ADDR_W'(1);
          end
        end
        ST_WDATA: begin
          if (wr_ok) begin
            mem_we          = ~protected_addr(addr, bp);
            next_wen        = 1'b0;
            next_commit_tgl = ~commit_tgl;
          end
          // writes wrap inside the current page
          next_addr[`EE_PAGE_BITS-1:0] =
            addr[`EE_PAGE_BITS-1:0] + `EE_PAGE_BITS'(1);
        end
        ST_RDATA: begin
          next_out_byte = mem[addr];
          next_addr     = addr + ADDR_W'(1);
        end
        ST_RSTAT: begin
          next_out_byte = status;
        end
        ST_WSTAT: begin
          if (wen && !busy_lnk) begin
            // protect pin low freezes the protected area, see RULE10
            if (wp_n_lnk) begin
              next_bp = in_byte[`EE_SR_BP_HI:`EE_SR_BP_LO];
            end
            next_wen        = 1'b0;
            next_commit_tgl = ~commit_tgl;
          end
          next_state = ST_IGNORE;
        end
        ST_IGNORE: begin
          next_state = ST_IGNORE;
        end
      endcase
    end

    // launch value for the coming fall, msb first, see RULE2 and RULE14
    next_so = out_byte[~bit_cnt];
    next_oe = (state == ST_RDATA) || (state == ST_RSTAT);
  end

  // frame state: raising select clears it at once, also while paused
  always_ff @(posedge I_SER_CLK or posedge I_SEL_N) begin
    if (I_SEL_N) begin // see RULE17
      state    <= ST_CMD;
      bit_cnt  <= 3'h0;
      shreg    <= 8'h00;
      addr     <= '0;
      out_byte <= 8'h00;
      is_write <= 1'b0;
      wr_ok    <= 1'b0;
    end else if (!armed_lnk) begin
      // not yet armed since power-up, see RULE6
      state    <= ST_IGNORE;
      bit_cnt  <= 3'h0;
      shreg    <= 8'h00;
      addr     <= '0;
      out_byte <= 8'h00;
      is_write <= 1'b0;
      wr_ok    <= 1'b0;
    end else begin
      state    <= next_state;
      bit_cnt  <= next_bit_cnt;
      shreg    <= next_shreg;
      addr     <= next_addr;
      out_byte <= next_out_byte;
      is_write <= next_is_write;
      wr_ok    <= next_wr_ok;
    end
  end

  // enable and protect bits outlive deselect; core reset clears them
  always_ff @(posedge I_SER_CLK) begin
    if (!armed_lnk) begin
      wen        <= `EE_WEN_RESET;
      bp         <= `EE_BP_RESET;
      commit_tgl <= 1'b0;
    end else begin
      wen        <= next_wen;
      bp         <= next_bp;
      commit_tgl <= next_commit_tgl;
    end
  end

  // storage has no reset; contents are undefined until written
  always_ff @(posedge I_SER_CLK) begin
    if (mem_we) begin
      mem[addr] <= in_byte;
    end
  end

  // output stage on falling edges; deselect or pause float it at once
  always_ff @(negedge I_SER_CLK or posedge float_req) begin
    if (float_req) begin // see RULE4 and RULE8
      O_SO    <= 1'b0;
      O_SO_OE <= 1'b0;
    end else begin // see RULE15 and RULE18
      O_SO    <= next_so;
      O_SO_OE <= next_oe;
    end
  end

endmodule // eeprom_spi_front_end
`default_nettype wire

// ---- verilog/eeprom_spi_params.svh ----
// constants and operation list of the serial eeprom front end
// Operation
// RULE1 - array of 1024 bytes, reachable only over the serial link
// RULE2 - each output bit is launched on a falling serial clock edge
// RULE3 - command, address and write data are captured on rising edges
// RULE4 - select high deselects the part and floats the data output
// RULE5 - deselected with no write running means standby, select low active
// RULE6 - after power-up, commands are ignored until select has fallen
// RULE7 - pause suspends the transfer while selected so it can resume
// RULE8 - while paused the output floats, clock and data input are ignored
// RULE9 - master asserts pause only while holding the part selected
// RULE10 - write-protect low freezes the two block-protect bits
// RULE11 - master keeps write-protect steady through every write command
// RULE12 - command, address and data bytes enter most significant bit first
// RULE13 - first input bit is taken on first rising edge after select falls
// RULE14 - read data starts on first falling edge after command, msb first
// RULE15 - only modes 0 and 3: sample on rise, change on fall
// RULE16 - master changes pause only while the serial clock is low
// RULE17 - deselect during pause resets the link, enable and busy survive
// RULE18 - output driven only selected, unpaused and in a read data phase
`ifndef EEPROM_SPI_PARAMS_SVH
`define EEPROM_SPI_PARAMS_SVH

`define EE_ARRAY_DEPTH 1024
`define EE_PAGE_BITS   5

`define EE_OP_WREN  8'h06
`define EE_OP_WRDI  8'h04
`define EE_OP_RDSR  8'h05
`define EE_OP_WRSR  8'h01
`define EE_OP_READ  8'h03
`define EE_OP_WRITE 8'h02

`define EE_SR_BUSY  0
`define EE_SR_WEN   1
`define EE_SR_BP_LO 2
`define EE_SR_BP_HI 3

`define EE_BP_RESET  2'h0
`define EE_WEN_RESET 1'b0

`define EE_T_WRITE_US 5000
`define EE_CORE_MHZ   100

`endif

// ---- verilog/eeprom_spi_pkg.sv ----
// types of the serial eeprom front end
`default_nettype none
package eeprom_spi_pkg;
  typedef enum logic [2:0] {
    ST_CMD,
    ST_ADDR_HI,
    ST_ADDR_LO,
    ST_WDATA,
    ST_RDATA,
    ST_RSTAT,
    ST_WSTAT,
    ST_IGNORE
  } link_state_e;
  typedef logic [7:0] byte_t;
endpackage
`default_nettype wire

// ---- verilog/eeprom_sync2.sv ----
// two flip-flop level synchroniser
`default_nettype none
module eeprom_sync2 #(
  parameter int WIDTH = 1
) (
  // clock of the receiving domain
  input  wire logic             i_clk,
  // levels from another domain
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;

  // meta is read by o_sync only
  always_ff @(posedge i_clk) begin
    meta   <= i_async;
    o_sync <= meta;
  end
endmodule // eeprom_sync2
`default_nettype wire

// ---- verification/eeprom_spi_monitor.sv ----
// port assertions of the serial eeprom front end
`default_nettype none
module eeprom_spi_monitor #(
  parameter int WRITE_CYCLES = 50
) (
  // core side
  input wire logic I_CORE_CLK,
  input wire logic I_RESETN,
  // link, seen through the faster core clock
  input wire logic I_SER_CLK,
  input wire logic I_SEL_N,
  input wire logic I_HOLD_N,
  input wire logic O_SO,
  input wire logic O_SO_OE,
  // status
  input wire logic O_STANDBY,
  input wire logic O_WRITE_BUSY,
  input wire logic O_PAUSED
);
  timeunit 1ns;
  timeprecision 100ps;
  int busy_run;
  int next_busy_run;
  default clocking @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RESETN);
  always_comb begin
    next_busy_run = (I_RESETN && O_WRITE_BUSY) ? busy_run + 1 : 0;
  end
  always_ff @(posedge I_CORE_CLK) begin
    busy_run <= next_busy_run;
  end
  a_desel_float: assert property (I_SEL_N |-> !O_SO_OE)
    else $error("output driven while deselected");
  a_pause_float: assert property (!I_HOLD_N |-> !O_SO_OE)
    else $error("output driven while paused");
  a_so_on_fall: assert property (
    $changed(O_SO) && !I_SEL_N && I_HOLD_N |-> !I_SER_CLK)
    else $error("data output moved outside a falling edge");
  a_oe_on_fall: assert property ($rose(O_SO_OE) |-> !I_SER_CLK)
    else $error("output enable rose outside a falling edge");
  a_oe_drop: assert property (
    $fell(O_SO_OE) |-> I_SEL_N || !I_HOLD_N)
    else $error("output enable dropped without cause");
  a_standby_wake: assert property (
    $fell(I_SEL_N) |-> ##[1:5] !O_STANDBY)
    else $error("standby kept after select");
  a_busy_awake: assert property (O_WRITE_BUSY |-> !O_STANDBY)
    else $error("standby during write timing");
  a_busy_span: assert property (
    $fell(O_WRITE_BUSY) |-> busy_run >= WRITE_CYCLES - 1)
    else $error("write timing too short");
  a_pause_seen: assert property (
    (!I_SEL_N && !I_HOLD_N) [*5] |-> O_PAUSED)
    else $error("pause not flagged");
  a_pause_gone: assert property (I_HOLD_N [*5] |-> !O_PAUSED)
    else $error("pause flag stuck");
endmodule // eeprom_spi_monitor
bind eeprom_spi_front_end eeprom_spi_monitor #(
  .WRITE_CYCLES(WRITE_CYCLES)
) mon (
  .I_CORE_CLK,
  .I_RESETN,
  .I_SER_CLK,
  .I_SEL_N,
  .I_HOLD_N,
  .O_SO,
  .O_SO_OE,
  .O_STANDBY,
  .O_WRITE_BUSY,
  .O_PAUSED
);
`default_nettype wire

// ---- verification/spi_master_model.sv ----
// serial bus master model driving the eeprom link
`default_nettype none
module spi_master_model (
  // link lines
  output logic     o_sclk,
  output logic     o_sel_n,
  output logic     o_si,
  output logic     o_hold_n,
  output logic     o_wp_n,
  // device answer
  input wire logic i_so,
  input wire logic i_so_oe,
  input wire logic i_paused
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 16;
  logic cpol = 1'b0;
  logic oe_seen;
  logic paused_seen;
  // select starts low, so the first frame has no falling edge
  initial begin
    o_sclk = 1'b0;
    o_sel_n = 1'b0;
    o_si = 1'b0;
    o_hold_n = 1'b1;
    o_wp_n = 1'b1;
  end
  task automatic idle(input logic mode);
    cpol = mode;
    o_sclk <= mode; // idle level of the mode
    #(4*HALF);
  endtask
  task automatic protect(input logic lvl);
    o_wp_n <= lvl; // steady level between frames
    #(4*HALF);
  endtask
  task automatic hold;
    o_sclk <= 1'b0;
    #HALF;
    o_hold_n <= 1'b0; // clock low and selected
    repeat (4) begin
      #HALF;
      o_sclk <= 1'b1;
      o_si <= ~o_si;
      #HALF;
      o_sclk <= 1'b0;
    end
    #HALF;
    paused_seen = i_paused;
    o_hold_n <= 1'b1;
    #HALF;
  endtask
  task automatic frame(input int n, input logic [39:0] tx,
                       input int pause_at, output logic [39:0] rx);
    rx = '0;
    oe_seen = 1'b0;
    o_sel_n <= 1'b0;
    #HALF;
    for (int k = 0; k < n; k++) begin
      if (k == pause_at) begin
        hold;
      end
      for (int i = 7; i >= 0; i--) begin
        o_sclk <= 1'b0;
        o_si <= tx[8*(n-1-k)+i]; // msb first
        #HALF;
        rx = {rx[38:0], i_so};
        oe_seen = oe_seen | i_so_oe;
        o_sclk <= 1'b1;
        #HALF;
      end
    end
    o_sclk <= cpol;
    #HALF;
    o_sel_n <= 1'b1;
    o_si <= ~o_si; // released line must not keep its last value
    #(4*HALF);
  endtask
endmodule // spi_master_model
`default_nettype wire

// ---- verification/eeprom_spi_front_end_test.sv ----
// bench of the serial eeprom front end
`default_nettype none
module eeprom_spi_front_end_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk;
  logic        resetn = 1'b0;
  logic [39:0] rx;
  int          fails = 0;
  int          samples_checked = 0;
  wire logic   sclk, sel_n, si, hold_n, wp_n;
  wire logic   so, so_oe, standby, busy, paused;
  eeprom_spi_front_end #(
    .WRITE_CYCLES(50)
  ) uut (
    .I_CORE_CLK  (clk),
    .I_RESETN    (resetn),
    .I_SER_CLK   (sclk),
    .I_SEL_N     (sel_n),
    .I_SI        (si),
    .I_HOLD_N    (hold_n),
    .I_WP_N      (wp_n),
    .O_SO        (so),
    .O_SO_OE     (so_oe),
    .O_STANDBY   (standby),
    .O_WRITE_BUSY(busy),
    .O_PAUSED    (paused)
  );
  spi_master_model m (
    .o_sclk  (sclk),
    .o_sel_n (sel_n),
    .o_si    (si),
    .o_hold_n(hold_n),
    .o_wp_n  (wp_n),
    .i_so    (so),
    .i_so_oe (so_oe),
    .i_paused(paused)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string what, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmd(input int n, input logic [39:0] tx);
    m.frame(n, tx, -1, rx);
  endtask
  // outlasts the shortened write timer
  task automatic settle;
    repeat (80) @(posedge clk);
  endtask
  task automatic t_power_up;
    cmd(2, 40'h0500);
    check("oe without select edge", m.oe_seen, 1'b0);
    cmd(1, 40'hff);
    check("standby", standby, 1'b1);
    $display("test power_up done");
  endtask
  task automatic t_write_read;
    cmd(1, 40'h06);
    m.frame(5, 40'h0203fea53c, 4, rx);
    check("paused", m.paused_seen, 1'b1);
    repeat (8) @(posedge clk);
    check("busy", busy, 1'b1);
    check("standby busy", standby, 1'b0);
    settle;
    check("standby idle", standby, 1'b1);
    cmd(5, 40'h0303fe0000);
    check("read mode0", rx[15:0], 16'ha53c);
    check("oe in read", m.oe_seen, 1'b1);
    $display("test write_read done");
  endtask
  task automatic t_mode3;
    m.idle(1'b1);
    cmd(5, 40'h0303fe0000);
    check("read mode3", rx[15:0], 16'ha53c);
    m.idle(1'b0);
    $display("test mode3 done");
  endtask
  task automatic t_protect;
    cmd(1, 40'h06);
    cmd(2, 40'h010c);
    settle;
    cmd(2, 40'h0500);
    check("bp set", rx[7:0] & 8'h0c, 8'h0c);
    m.protect(1'b0);
    cmd(1, 40'h06);
    cmd(2, 40'h0100);
    settle;
    cmd(2, 40'h0500);
    check("bp frozen", rx[7:0] & 8'h0c, 8'h0c);
    cmd(1, 40'h06);
    cmd(4, 40'h0203fe00);
    settle;
    cmd(4, 40'h0303fe00);
    check("protected byte", rx[7:0], 8'ha5);
    $display("test protect done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_power_up;
    t_write_read;
    t_mode3;
    t_protect;
    give_verdict;
  end
  initial begin
    #100us;
    fails++;
    give_verdict;
  end
endmodule // eeprom_spi_front_end_test
`default_nettype wire
